// File: test/ppsg_sva.sv
// Port checker for ppsg_top.
// Bound into ppsg_top; sees only its ports.
`timescale 1ns/1ps
module ppsg_sva
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire ppsg_pkg::ppsg_straps_t i_straps,
  input wire logic i_pause,
  input wire logic i_emu_access,
  input wire logic i_final_bus_state,
  input wire logic i_status_active,
  input wire logic o_transmit_receive_direction,
  input wire ppsg_pkg::ppsg_selects_t o_selects,
  input wire logic o_address_latch_strobe,
  input wire logic o_timer0_input,
  input wire ppsg_pkg::ppsg_clk_path_t o_clock_path,
  input wire logic o_clock_path_invalid
);
  wire logic hold = i_pause && !i_emu_access;
  wire logic late = i_straps.strobe_strap;
  wire logic ale = o_address_latch_strobe;
  wire logic [1:0] cpv = {i_straps.clock_path_strap, i_straps.clock_path_second_strap};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_dir_level: assert property (i_pause |=> o_transmit_receive_direction ==
    $past(i_straps.pause_direction_strap)) else $error("dir");
  a_low_gated: assert property (hold && i_straps.low_select_gating_strap |=>
    &o_selects[9:5]) else $error("low sel");
  a_high_gated: assert property (hold && i_straps.high_select_strap |=>
    &o_selects[4:0]) else $error("high sel");
  a_clk_decode: assert property (1 |=> o_clock_path == $past(cpv)) else $error("cp");
  a_clk_bad: assert property (1 |=> o_clock_path_invalid == ($past(cpv) == 2'h3))
    else $error("inv");
  a_early_rise: assert property (!late && i_final_bus_state |=> ale) else $error("early");
  a_late_rise: assert property (late && i_status_active |=> ale) else $error("late");
  a_timer_block: assert property (i_straps.timer_strap && i_pause |=>
    !o_timer0_input) else $error("tmr");
  c_late: cover property (late && i_status_active);
  c_gate: cover property (hold && i_straps.low_select_gating_strap);
  c_bad: cover property (o_clock_path_invalid);
endmodule
bind ppsg_top ppsg_sva i_ppsg_sva
(
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_straps(i_straps),
  .i_pause(i_pause),
  .i_emu_access(i_emu_access),
  .i_final_bus_state(i_final_bus_state),
  .i_status_active(i_status_active),
  .o_transmit_receive_direction(o_transmit_receive_direction),
  .o_selects(o_selects),
  .o_address_latch_strobe(o_address_latch_strobe),
  .o_timer0_input(o_timer0_input),
  .o_clock_path(o_clock_path),
  .o_clock_path_invalid(o_clock_path_invalid)
);

// File: test/ppsg_target.sv
// Target model: drives both timer pins from one level.
// Assumes the target changes the pins off the processor clock.
`timescale 1ns/1ps
module ppsg_target
(
  input wire logic i_level,
  output logic o_pin0,
  output logic o_pin1
);
  assign o_pin0 = i_level;
  assign o_pin1 = i_level;
endmodule

// File: test/ppsg_top_tb_top.sv
// Bench for ppsg_top: loop and table driven port checks.
// Assumes the target model drives the timer pins.
`timescale 1ns/1ps
module ppsg_top_tb_top;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_cpu_direction = 1'b0, lvl = 1'b0;
  logic i_pause, i_emu_access, i_final_bus_state, i_idle_bus_state, i_status_active;
  logic i_cpu_strobe, i_timer0_external_input, i_timer1_external_input;
  logic o_transmit_receive_direction, o_address_latch_strobe, o_timer0_input;
  logic o_timer1_input, o_clock_path_invalid;
  logic [5:0] ctl = 6'h01;
  ppsg_pkg::ppsg_straps_t i_straps = '0;
  ppsg_pkg::ppsg_selects_t i_cpu_selects = 10'h2A5, o_selects;
  ppsg_pkg::ppsg_clk_path_t o_clock_path;
  // Strobe steps: strap, expected, then the six bus controls
  logic [7:0] seq [6] = '{8'h49, 8'h44, 8'h00, 8'h89, 8'hC3, 8'h80};
  int n_errors = 0, n_compared = 0, cyc = 0;
  assign {i_pause, i_emu_access, i_final_bus_state, i_idle_bus_state, i_status_active,
    i_cpu_strobe} = ctl;
  ppsg_top i_ppsg_top
  (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_straps(i_straps),
    .i_pause(i_pause),
    .i_emu_access(i_emu_access),
    .i_cpu_direction(i_cpu_direction),
    .i_cpu_selects(i_cpu_selects),
    .i_final_bus_state(i_final_bus_state),
    .i_idle_bus_state(i_idle_bus_state),
    .i_status_active(i_status_active),
    .i_cpu_strobe(i_cpu_strobe),
    .i_timer0_external_input(i_timer0_external_input),
    .i_timer1_external_input(i_timer1_external_input),
    .o_transmit_receive_direction(o_transmit_receive_direction),
    .o_selects(o_selects),
    .o_address_latch_strobe(o_address_latch_strobe),
    .o_timer0_input(o_timer0_input),
    .o_timer1_input(o_timer1_input),
    .o_clock_path(o_clock_path),
    .o_clock_path_invalid(o_clock_path_invalid)
  );
  ppsg_target i_ppsg_target (.i_level(lvl), .o_pin0(i_timer0_external_input),
    .o_pin1(i_timer1_external_input));
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (++cyc > 400)
      tally_and_finish(1);
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string nm);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input logic [5:0] v, input int n);
    ctl = v;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic tally_and_finish(input int e);
    n_errors += e;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    go(6'h01, 5);
    i_arst_n = 1'b1;
    lvl = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      i_straps[6:4] = {k[0], k[0], ~k[0]};
      i_cpu_direction = k[2];
      go({k[1], k[2], 4'h1}, 1);
      chk(o_transmit_receive_direction, k[1] ? k[0] : k[2], "dir");
      chk(o_selects[9:5], (k[0] & k[1] & ~k[2]) ? 5'h1F : i_cpu_selects[9:5], "lo");
      chk(o_selects[4:0], (~k[0] & k[1] & ~k[2]) ? 5'h1F : i_cpu_selects[4:0], "hi");
    end
    for (int c = 0; c < 4; c++)
    begin
      i_straps[2:1] = c[1:0];
      go(6'h01, 1);
      chk(o_clock_path, c[1:0], "cp");
      chk(o_clock_path_invalid, c == 3, "inv");
    end
    foreach (seq[j])
    begin
      i_straps[3] = seq[j][7];
      go(seq[j][5:0], 1);
      chk(o_address_latch_strobe, seq[j][6], "ale");
    end
    go(6'h21, 3);
    chk({o_timer0_input, o_timer1_input}, 2'h3, "tmr");
    i_straps[0] = 1'b1;
    go(6'h21, 1);
    chk({o_timer0_input, o_timer1_input}, 2'h0, "tmr");
    tally_and_finish(0);
  end
endmodule

// File: verilog/ppsg_pkg.sv
// Package for the pod pause signal gating block: strap codes, modes, carriers.
// Assumes straps are static and run/pause comes from the emulator controller.
package ppsg_pkg;

  // Strap positions: 0 = pins 1-2 joined, 1 = pins 2-3 joined
  localparam logic STRAP_1_2 = 1'b0;
  localparam logic STRAP_2_3 = 1'b1;

  localparam int NUM_HIGH_SEL = 5;
  localparam int NUM_LOW_PSEL = 2;

  typedef enum logic [1:0]
  {
    PPSG_CLK_FULL = 2'b00,
    PPSG_CLK_PARTIAL = 2'b01,
    PPSG_CLK_BYPASS = 2'b10,
    PPSG_CLK_INVALID = 2'b11
  } ppsg_clk_path_t;

  typedef struct packed
  {
    logic pause_direction_strap;
    logic low_select_gating_strap;
    logic high_select_strap;
    logic strobe_strap;
    logic clock_path_strap;
    logic clock_path_second_strap;
    logic timer_strap;
  } ppsg_straps_t;

  // Chip selects, active low as on the processor
  typedef struct packed
  {
    logic upper_memory_select_n;
    logic lower_memory_select_n;
    logic mid_range_memory_select_n;
    logic [NUM_LOW_PSEL-1:0] peripheral_selects_low_n;
    logic [NUM_HIGH_SEL-1:0] peripheral_selects_high_n;
  } ppsg_selects_t;

  localparam ppsg_selects_t SELECTS_IDLE = '1;

  // Output levels while reset is asserted
  localparam logic DIRECTION_RESET = 1'h0;
  localparam logic STROBE_RESET = 1'h0;
  localparam logic TIMER_INPUT_RESET = 1'h0;
  localparam logic SYNC_RESET = 1'h0;
  localparam logic CLK_INVALID_RESET = 1'h0;
  localparam ppsg_clk_path_t CLK_PATH_RESET = PPSG_CLK_FULL;

endpackage

// File: verilog/ppsg_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes a free-running processor clock.
`timescale 1ns/1ps
module ppsg_sync
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_d,
  output logic o_q
);

  logic meta;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta <= ppsg_pkg::SYNC_RESET;
      o_q <= ppsg_pkg::SYNC_RESET;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule

// File: verilog/ppsg_top.sv
// Pod pause signal gating: conditions processor bus signals toward the target.
// Assumes straps static, run/pause and emulator access from the controller on
// the processor clock, and bus status/state inputs from the pod processor.
// Timer pins come straight from the target and are synchronised here.
//
// How it works
// - Pause drives direction at strap level
// - Low selects gated by their strap
// - High peripheral selects gated by own strap
// - Two straps decode clock path choice
// - Early strobe rises at final bus state
// - Late strobe rises after status active
// - Strobe falls at normal processor time
// - Early strobe held high through idle
// - Strobe strap defaults to early mode
// - Timer strap 1-2 passes timer inputs
// - Timer strap 2-3 blocks inputs in pause
// - Timer 2 has no external input
`timescale 1ns/1ps
module ppsg_top
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire ppsg_pkg::ppsg_straps_t i_straps,
  input wire logic i_pause,
  input wire logic i_emu_access,
  input wire logic i_cpu_direction,
  input wire ppsg_pkg::ppsg_selects_t i_cpu_selects,
  input wire logic i_final_bus_state,
  input wire logic i_idle_bus_state,
  input wire logic i_status_active,
  input wire logic i_cpu_strobe,
  input wire logic i_timer0_external_input,
  input wire logic i_timer1_external_input,
  output logic o_transmit_receive_direction,
  output ppsg_pkg::ppsg_selects_t o_selects,
  output logic o_address_latch_strobe,
  output logic o_timer0_input,
  output logic o_timer1_input,
  output ppsg_pkg::ppsg_clk_path_t o_clock_path,
  output logic o_clock_path_invalid
);

  ////////////////////////////////////////////////////////////////////////////
  // Timer inputs come from target pins, so they are synchronised first
  // The two flops cost two clocks of latency on each timer pin

  logic tmr0_sync;
  logic tmr1_sync;

  ppsg_sync u_sync_tmr0
  (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_timer0_external_input),
    .o_q(tmr0_sync)
  );

  ppsg_sync u_sync_tmr1
  (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_timer1_external_input),
    .o_q(tmr1_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gating decode

  // Emulator accesses during pause count as run for the gated selects
  wire run_or_access = !i_pause || i_emu_access;
  wire low_free_in_pause = (i_straps.low_select_gating_strap == ppsg_pkg::STRAP_1_2);
  wire high_free_in_pause = (i_straps.high_select_strap == ppsg_pkg::STRAP_1_2);
  wire pass_low = low_free_in_pause || run_or_access;
  wire pass_high = high_free_in_pause || run_or_access;
  // A fixed pause level keeps the target transceivers from turning around
  wire pause_dir = (i_straps.pause_direction_strap == ppsg_pkg::STRAP_2_3);
  wire next_direction = i_pause ? pause_dir : i_cpu_direction;

  ppsg_pkg::ppsg_selects_t next_selects;
  always_comb
  begin
    next_selects = ppsg_pkg::SELECTS_IDLE;
    if (pass_low)
    begin
      next_selects.upper_memory_select_n = i_cpu_selects.upper_memory_select_n;
      next_selects.lower_memory_select_n = i_cpu_selects.lower_memory_select_n;
      next_selects.mid_range_memory_select_n = i_cpu_selects.mid_range_memory_select_n;
      next_selects.peripheral_selects_low_n = i_cpu_selects.peripheral_selects_low_n;
    end
    if (pass_high)
    begin
      next_selects.peripheral_selects_high_n = i_cpu_selects.peripheral_selects_high_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer pin gating

  // Strap 1-2 keeps the pins open; the pause-enable soft switches inside
  // the timers then decide whether pause activity is counted
  wire timers_always_open = (i_straps.timer_strap == ppsg_pkg::STRAP_1_2);
  // Strap 2-3 is for targets that glitch the pins while halted
  wire pass_timers = timers_always_open || !i_pause;
  wire next_tmr0 = pass_timers & tmr0_sync;
  wire next_tmr1 = pass_timers & tmr1_sync;
  // Timer 2 only counts internal events, so no pin path exists for it

  ////////////////////////////////////////////////////////////////////////////
  // Clock path selection

  wire [1:0] clk_code = {i_straps.clock_path_strap, i_straps.clock_path_second_strap};
  wire ppsg_pkg::ppsg_clk_path_t next_clock_path = ppsg_pkg::ppsg_clk_path_t'(clk_code);
  // The forbidden pair still shows its code, so a bad strap can be seen
  wire next_clock_invalid = (next_clock_path == ppsg_pkg::PPSG_CLK_INVALID);

  ////////////////////////////////////////////////////////////////////////////
  // Address latch strobe: the rising edge and the idle hold move with the strap

  // Strap 1-2 is the shipped setting, so the zero code means early mode
  wire early_mode = (i_straps.strobe_strap == ppsg_pkg::STRAP_1_2);
  wire rise_early = early_mode && i_final_bus_state;
  // Late rise waits for status, one clock before the first bus state
  wire rise_late = !early_mode && i_status_active;
  wire strobe_rise = rise_early || rise_late;
  // Early pulse cannot know if idle states follow, so it is stretched
  wire in_final_or_idle = i_idle_bus_state || i_final_bus_state;
  wire strobe_hold = o_address_latch_strobe && early_mode && in_final_or_idle;
  // Processor strobe low marks the normal trailing edge in both modes
  wire cpu_strobe_low = !i_cpu_strobe;
  wire strobe_fall = o_address_latch_strobe && cpu_strobe_low && !strobe_hold;
  // A new rise wins over a fall in the same clock
  wire next_strobe = strobe_rise || (o_address_latch_strobe && !strobe_fall);

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs, all on the processor clock

  // Each output has a flip-flop of its own on the processor clock, so the
  // target never sees a decode glitch
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_transmit_receive_direction <= ppsg_pkg::DIRECTION_RESET;
    end
    else
    begin
      o_transmit_receive_direction <= next_direction;
    end
  end

  // Gated groups read all ones, the idle level of the active-low selects
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_selects <= ppsg_pkg::SELECTS_IDLE;
    end
    else
    begin
      o_selects <= next_selects;
    end
  end

  // The strobe reads its own register back for hold and fall
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_address_latch_strobe <= ppsg_pkg::STROBE_RESET;
    end
    else
    begin
      o_address_latch_strobe <= next_strobe;
    end
  end

  // Timer pins reach the processor timers three clocks after they change
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_timer0_input <= ppsg_pkg::TIMER_INPUT_RESET;
    end
    else
    begin
      o_timer0_input <= next_tmr0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_timer1_input <= ppsg_pkg::TIMER_INPUT_RESET;
    end
    else
    begin
      o_timer1_input <= next_tmr1;
    end
  end

  // Path code and invalid flag always move together
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_clock_path <= ppsg_pkg::CLK_PATH_RESET;
    end
    else
    begin
      o_clock_path <= next_clock_path;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_clock_path_invalid <= ppsg_pkg::CLK_INVALID_RESET;
    end
    else
    begin
      o_clock_path_invalid <= next_clock_invalid;
    end
  end

endmodule
